// ===== hdl/uart_baud_timing.sv
/*
  serial_port_unit bit timing: base clock prescaler, transmit and
  receive bit counters, an 8-word transmit fifo and an axi4-lite slave.
  assumes one clock (aclk), synchronous active-low reset, and a serial
  input already synchronous to aclk.
*/
// Contract
// - divisor is 8 bits, only 8..255 accepted
// - bit rate is base clock over 2k
// - 4-bit field selects base clock source
// - receive samples timed by divisor counter
// - frame good only if stop bit sampled high
// - sample margin about k base clocks per frame
// - back-to-back stop bit gets two extra ticks
// - receiver restarts timing at each start bit
// - rx counter cleared when off, runs per frame
// - base clock low when off; tx counter cleared
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// fifo: parameterised width and depth, valid/ready on both sides
// ------------------------------------------------------------------
module tx_word_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // storage words
  logic [AW-1:0]    wr_ptr;        // next slot to fill
  logic [AW-1:0]    rd_ptr;        // oldest slot
  logic [AW:0]      count;         // words held
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage has no reset; only count decides what is valid
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers wrap at depth, so depth need not be a power of two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ------------------------------------------------------------------
// top: register slave plus transmit and receive timing
// ------------------------------------------------------------------
module uart_baud_timing
  import uart_baud_pkg::*;
#(
  parameter int unsigned FIFO_WORDS = FIFO_DEPTH
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        serial_rx,
  output logic             serial_tx
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  serial_ctrl_s ctrl;              // enables
  logic [3:0]  base_clock_select;  // prescaler code
  logic [7:0]  bit_divisor_value;  // k
  logic [15:0] presc;              // free prescaler, held clear when off
  logic [15:0] sel_mask;           // low n bits set
  logic        base_tick;          // one base clock period elapsed
  logic [8:0]  bit_last;           // 2k-1: last tick of a bit
  logic [8:0]  half_last;          // k-1: middle of start bit
  logic        aw_held, w_held;    // write halves captured
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;            // write performed this cycle
  logic        wr_map;             // write address is mapped
  logic        fifo_in_ready, fifo_out_valid, tx_take;
  logic [7:0]  fifo_out_data;
  logic        rd_take;            // read address accepted
  logic        rx_read;            // rxdata read clears rx_full
  tx_state_e   tx_state;
  logic [8:0]  tx_cnt;             // transmission counter
  logic [1:0]  stretch_cnt;
  logic [3:0]  tx_bits;
  logic [7:0]  tx_shift;
  logic        tx_bit_done;
  rx_state_e   rx_state;
  logic [8:0]  rx_cnt;             // reception counter
  logic [3:0]  rx_bits;
  logic [7:0]  rx_shift, rx_buf;
  logic        rx_prev;            // last serial_rx for edge detect
  logic        rx_full, frame_err, overrun;
  logic        rx_tick_hit;

  // ----------------------------------------------------------------
  // base clock: aclk / 2^n, stopped and cleared while powered off
  // ----------------------------------------------------------------
  assign sel_mask  = (16'h0001 << base_clock_select) - 16'h0001;
  assign base_tick = ctrl.power && ((presc & sel_mask) == sel_mask);
  assign bit_last  = {bit_divisor_value, 1'b0} - 9'h001;
  assign half_last = {1'b0, bit_divisor_value} - 9'h001;

  // prescaler only runs with power, so the base clock stays low
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl.power) begin
      presc <= '0;
    end else begin
      presc <= presc + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_map  = (aw_addr <= ADDR_RXDATA) && (aw_addr[1:0] == 2'h0);
  // a txdata write waits for fifo room: back-pressure via bvalid
  assign wr_fire = aw_held && w_held && !s_axi_bvalid &&
                   (aw_addr != ADDR_TXDATA || fifo_in_ready);

  // capture each half, perform when both are present
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers; all fields live in byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl              <= '0;
      base_clock_select <= CLKSEL_RESET;
      bit_divisor_value <= DIV_RESET;
    end else if (wr_fire && w_strb[0]) begin
      case (aw_addr)
        ADDR_CTRL: begin
          ctrl <= '{w_data[CTRL_POWER_BIT], w_data[CTRL_TXE_BIT], w_data[CTRL_RXE_BIT]};
        end
        ADDR_CLKSEL: begin
          base_clock_select <= w_data[3:0];
        end
        ADDR_DIVISOR: begin
          // values below the minimum are ignored, old divisor kept
          if (w_data[7:0] >= DIV_MIN && w_data[7:0] <= DIV_MAX) begin
            bit_divisor_value <= w_data[7:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel: one cycle to answer
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take       = s_axi_arvalid && s_axi_arready;
  assign rx_read       = rd_take && (s_axi_araddr == ADDR_RXDATA);

  // read mux registered into rdata
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= '0;
      case (s_axi_araddr)
        ADDR_CTRL: begin
          s_axi_rdata[CTRL_POWER_BIT] <= ctrl.power;
          s_axi_rdata[CTRL_TXE_BIT]   <= ctrl.txe;
          s_axi_rdata[CTRL_RXE_BIT]   <= ctrl.rxe;
        end
        ADDR_CLKSEL:  s_axi_rdata[3:0] <= base_clock_select;
        ADDR_DIVISOR: s_axi_rdata[7:0] <= bit_divisor_value;
        ADDR_STATUS: begin
          s_axi_rdata[ST_FIFO_EMPTY] <= !fifo_out_valid;
          s_axi_rdata[ST_FIFO_FULL]  <= !fifo_in_ready;
          s_axi_rdata[ST_RX_FULL]    <= rx_full;
          s_axi_rdata[ST_FRAME_ERR]  <= frame_err;
          s_axi_rdata[ST_OVERRUN]    <= overrun;
          s_axi_rdata[ST_TX_BUSY]    <= (tx_state != TX_IDLE);
          s_axi_rdata[ST_RX_BUSY]    <= (rx_state != RX_IDLE);
        end
        ADDR_RXDATA:  s_axi_rdata[7:0] <= rx_buf;
        ADDR_TXDATA:  s_axi_rdata      <= '0; // write-only, reads zero
        default:      s_axi_rresp      <= RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transmit fifo and transmitter
  // ----------------------------------------------------------------
  tx_word_fifo #(.WIDTH(8), .DEPTH(FIFO_WORDS)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   (w_data[7:0]),
    .in_valid  (wr_fire && aw_addr == ADDR_TXDATA),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (tx_take)
  );

  assign tx_bit_done = base_tick && (tx_cnt == bit_last);
  // next word taken from idle, or once the stop stretch has run out
  assign tx_take = ctrl.power && ctrl.txe && fifo_out_valid &&
                   ((tx_state == TX_IDLE) ||
                    (tx_state == TX_STRETCH && base_tick &&
                     stretch_cnt == STRETCH_TICKS - 2'h1));

  // frame: start, eight data bits lsb first, stop
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl.power || !ctrl.txe) begin
      tx_state    <= TX_IDLE;
      tx_cnt      <= '0;
      stretch_cnt <= '0;
      tx_bits     <= '0;
      tx_shift    <= '0;
      serial_tx   <= 1'b1;
    end else begin
      if (tx_take) begin
        tx_cnt <= '0; // counter restarts with each frame
      end else if (base_tick) begin
        tx_cnt <= (tx_cnt == bit_last) ? '0 : tx_cnt + 9'h001;
      end
      case (tx_state)
        TX_IDLE, TX_STRETCH: begin
          if (tx_take) begin
            tx_state  <= TX_START;
            tx_shift  <= fifo_out_data;
            serial_tx <= 1'b0;
          end else if (tx_state == TX_STRETCH && base_tick) begin
            stretch_cnt <= stretch_cnt + 2'h1;
          end
        end
        TX_START: begin
          if (tx_bit_done) begin
            tx_state  <= TX_DATA;
            tx_bits   <= '0;
            serial_tx <= tx_shift[0];
          end
        end
        TX_DATA: begin
          if (tx_bit_done) begin
            tx_bits  <= tx_bits + 4'h1;
            tx_shift <= {1'b0, tx_shift[7:1]};
            if (tx_bits == FRAME_DATA_BITS - 4'h1) begin
              tx_state  <= TX_STOP;
              serial_tx <= 1'b1;
            end else begin
              serial_tx <= tx_shift[1];
            end
          end
        end
        TX_STOP: begin
          if (tx_bit_done) begin
            // back to back: stop bit grows by two base ticks
            tx_state    <= fifo_out_valid ? TX_STRETCH : TX_IDLE;
            stretch_cnt <= '0;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receiver: timing restarts at every start bit
  // ----------------------------------------------------------------
  // sampling mid-bit leaves about k base ticks either side; the
  // far transmitter must stay within that tolerance
  assign rx_tick_hit = base_tick &&
                       (rx_cnt == ((rx_state == RX_START) ? half_last : bit_last));

  // frame reception and sticky status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state  <= RX_IDLE;
      rx_cnt    <= '0;
      rx_bits   <= '0;
      rx_shift  <= '0;
      rx_buf    <= '0;
      rx_prev   <= 1'b1;
      rx_full   <= 1'b0;
      frame_err <= 1'b0;
      overrun   <= 1'b0;
    end else begin
      rx_prev <= serial_rx;
      // clears first, so a same-cycle set below wins
      if (rx_read) begin
        rx_full <= 1'b0;
      end
      if (wr_fire && aw_addr == ADDR_STATUS && w_strb[0]) begin
        frame_err <= frame_err & ~w_data[ST_FRAME_ERR];
        overrun   <= overrun & ~w_data[ST_OVERRUN];
      end
      if (!ctrl.power || !ctrl.rxe) begin
        rx_state <= RX_IDLE;
        rx_cnt   <= '0;
      end else begin
        if (rx_state == RX_IDLE || rx_tick_hit) begin
          rx_cnt <= '0;
        end else if (base_tick) begin
          rx_cnt <= rx_cnt + 9'h001;
        end
        case (rx_state)
          RX_IDLE: begin
            if (rx_prev && !serial_rx) begin
              rx_state <= RX_START;
            end
          end
          RX_START: begin
            // half a bit in: start still low, else treat as glitch
            if (rx_tick_hit) begin
              rx_state <= serial_rx ? RX_IDLE : RX_DATA;
              rx_bits  <= '0;
            end
          end
          RX_DATA: begin
            if (rx_tick_hit) begin
              rx_shift <= {serial_rx, rx_shift[7:1]};
              rx_bits  <= rx_bits + 4'h1;
              if (rx_bits == FRAME_DATA_BITS - 4'h1) begin
                rx_state <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (rx_tick_hit) begin
              rx_state <= RX_IDLE; // counter stops until next start
              if (serial_rx) begin
                rx_buf  <= rx_shift;
                rx_full <= 1'b1;
                if (rx_full && !rx_read) begin
                  overrun <= 1'b1;
                end
              end else begin
                frame_err <= 1'b1;
              end
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== inc/uart_baud_pkg.sv
/*
  shared constants and types for the serial bit-timing block:
  register offsets, field positions, reset values and state enums.
  assumes a 32-bit axi4-lite register bus with byte addressing.
*/
`default_nettype none
package uart_baud_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00; // power / tx / rx enables
  localparam logic [7:0] ADDR_CLKSEL  = 8'h04; // clock_source_select_reg
  localparam logic [7:0] ADDR_DIVISOR = 8'h08; // bit_divisor_reg
  localparam logic [7:0] ADDR_STATUS  = 8'h0C; // sticky and live state
  localparam logic [7:0] ADDR_TXDATA  = 8'h10; // write pushes the tx fifo
  localparam logic [7:0] ADDR_RXDATA  = 8'h14; // read takes received byte
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_POWER_BIT  = 7; // serial_power_on
  localparam int unsigned CTRL_TXE_BIT    = 6; // transmit_enable_bit
  localparam int unsigned CTRL_RXE_BIT    = 5; // receive_enable_bit
  localparam int unsigned ST_FIFO_EMPTY   = 0;
  localparam int unsigned ST_FIFO_FULL    = 1;
  localparam int unsigned ST_RX_FULL      = 2;
  localparam int unsigned ST_FRAME_ERR    = 3;
  localparam int unsigned ST_OVERRUN      = 4;
  localparam int unsigned ST_TX_BUSY      = 5;
  localparam int unsigned ST_RX_BUSY      = 6;
  // ----------------------------------------------------------------
  // reset values, limits and counts
  // ----------------------------------------------------------------
  localparam logic [3:0] CLKSEL_RESET   = 4'h0;
  localparam logic [7:0] DIV_RESET      = 8'hFF;
  localparam logic [7:0] DIV_MIN        = 8'h08;
  localparam logic [7:0] DIV_MAX        = 8'hFF;
  localparam logic [1:0] STRETCH_TICKS  = 2'h2; // extra base ticks on stop
  localparam logic [3:0] FRAME_DATA_BITS = 4'h8;
  localparam int unsigned FIFO_DEPTH    = 8;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic power; // serial_power_on
    logic txe;   // transmit_enable_bit
    logic rxe;   // receive_enable_bit
  } serial_ctrl_s;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_STRETCH} tx_state_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
endpackage
`default_nettype wire

// ===== testbench/uart_baud_timing_properties.sv
/* checker of the bus handshakes and the serial line timing.
   assumes it is bound to uart_baud_timing and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module uart_baud_timing_properties
  import uart_baud_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        serial_tx
);
  logic       last_tx; // line level one cycle back
  logic [7:0] run;     // cycles the level has held, saturating
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // run length of the line; saturates so idle never wraps to a short run
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_tx <= 1'b1;
      run     <= 8'hFF;
    end else begin
      last_tx <= serial_tx;
      if (serial_tx != last_tx) run <= 8'h01;
      else if (run != 8'hFF) run <= run + 8'h01;
    end
  end
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped early");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  read_ok_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= ADDR_RXDATA
    && s_axi_araddr[1:0] == 2'h0 |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY
    && s_axi_rdata[31:8] == 24'h0) else $error("mapped read answered wrongly");
  read_err_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_RXDATA
    |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered wrongly");
  write_err_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && s_axi_awaddr > ADDR_RXDATA |-> ##2 s_axi_bvalid
    && s_axi_bresp == RESP_SLVERR) else $error("unmapped write answered wrongly");
  // shortest legal bit is 2k base ticks with k at least 8
  bit_width_a:
    assert property (last_tx && !serial_tx |-> run >= 8'h10)
    else $error("serial high stretch shorter than one bit");
endmodule
bind uart_baud_timing uart_baud_timing_properties chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .serial_tx(serial_tx));
`default_nettype wire

// ===== testbench/serial_partner.sv
/* remote serial node: sends frames onto the receive line and
   decodes frames from the transmit line. assumes one aclk domain. */
`timescale 1ns/1ps
`default_nettype none
module serial_partner (
  input  wire logic aclk,
  input  wire logic tx_line,
  output logic      rx_line
);
  initial rx_line = 1'b1; // idle high
  // one frame, lsb first; cyc is the far end's own bit length
  task automatic send(input logic [7:0] b, input int cyc, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (cyc) @(posedge aclk);
    end
    // a broken stop still returns the line to idle
    if (!stop) begin
      rx_line <= 1'b1;
      repeat (cyc) @(posedge aclk);
    end
  endtask
  // wait for a start edge, then sample each data bit at its middle
  task automatic catch(input int cyc, output logic [7:0] b, output realtime t0);
    do @(negedge aclk); while (tx_line !== 1'b0);
    t0 = $realtime;
    repeat (cyc / 2) @(negedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (cyc) @(negedge aclk);
      b[i] = tx_line;
    end
  endtask
endmodule
`default_nettype wire

// ===== testbench/uart_baud_timing_tb_top.sv
/* self-checking bench: register table, transmit timing, reception,
   fifo fill and drain, second reset. assumes the serial_partner model. */
`timescale 1ns/1ps
`default_nettype none
module uart_baud_timing_tb_top;
  import uart_baud_pkg::*;
  typedef struct { logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r; } row_s;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic serial_rx, serial_tx, bready, rready; // readies raised late so answers must stand
  logic [7:0]  awaddr, araddr, b0, b1;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  bresp, rresp, r;
  realtime     t0, t1;
  int          n_mismatch, checks;
  // write, read back; includes a rejected divisor and an unmapped address
  row_s rows [8] = '{'{ADDR_CLKSEL, 32'h3, 32'h3, RESP_OKAY},
    '{ADDR_CLKSEL, 32'h0, 32'h0, RESP_OKAY}, '{ADDR_DIVISOR, 32'h8, 32'h8, RESP_OKAY},
    '{ADDR_DIVISOR, 32'h7, 32'h8, RESP_OKAY}, '{ADDR_DIVISOR, 32'hFF, 32'hFF, RESP_OKAY},
    '{ADDR_CTRL, 32'hE0, 32'hE0, RESP_OKAY}, '{ADDR_CTRL, 32'h0, 32'h0, RESP_OKAY},
    '{8'h18, 32'h55, 32'h0, RESP_SLVERR}};
  uart_baud_timing uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_rx(serial_rx), .serial_tx(serial_tx));
  serial_partner p (.aclk(aclk), .tx_line(serial_tx), .rx_line(serial_rx));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // write: both halves offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic ah, wh, ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ah = awready && !ad;
      wh = wready && !wd;
      @(posedge aclk);
      if (ah) begin
        awvalid <= 1'b0;
        ad = 1;
      end
      if (wh) begin
        wvalid <= 1'b0;
        wd = 1;
      end
    end
    // bready follows bvalid by a cycle, so the response has to hold
    do @(negedge aclk); while (!bvalid);
    rs = bresp;
    @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic h;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      h = arready;
      @(posedge aclk);
    end while (!h);
    arvalid <= 1'b0;
    // rready follows rvalid by a cycle, so the read data has to hold
    do @(negedge aclk); while (!rvalid);
    d = rdata;
    rs = rresp;
    @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // two back-to-back frames; start edges 10 bits plus 2 base ticks apart
  task automatic pair(input int cyc);
    fork
      begin
        p.catch(cyc, b0, t0);
        p.catch(cyc, b1, t1);
      end
      begin
        wr(ADDR_TXDATA, 32'hA5, r);
        wr(ADDR_TXDATA, 32'hC3, r);
      end
    join
    chk(b0, 8'hA5);
    chk(b1, 8'hC3);
    chk(32'((t1 - t0) / 4.0), 32'(10 * cyc + 2 * cyc / 16));
    repeat (100) @(posedge aclk);
  endtask
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata, bready, rready} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, r);
      chk(32'(r), 32'(rows[i].r));
      rd(rows[i].a, v, r);
      chk(v, rows[i].e);
      chk(32'(r), 32'(rows[i].r));
    end
    wr(ADDR_DIVISOR, 32'h8, r);
    wr(ADDR_CTRL, 32'hC0, r);
    pair(16);
    wr(ADDR_CLKSEL, 32'h1, r);
    pair(32);
    wr(ADDR_CLKSEL, 32'h0, r);
    wr(ADDR_DIVISOR, 32'h14, r);
    wr(ADDR_CTRL, 32'hA0, r);
    p.send(8'h5A, 41, 1'b1);
    rd(ADDR_STATUS, v, r);
    chk(32'(v[4:2]), 32'h1);
    rd(ADDR_RXDATA, v, r);
    chk(v, 32'h5A);
    p.send(8'hF0, 40, 1'b0);
    rd(ADDR_STATUS, v, r);
    chk(32'(v[4:2]), 32'h2);
    wr(ADDR_STATUS, 32'h08, r);
    p.send(8'h33, 40, 1'b1);
    p.send(8'h96, 40, 1'b1);
    rd(ADDR_STATUS, v, r);
    chk(32'(v[4:2]), 32'h5);
    rd(ADDR_RXDATA, v, r);
    chk(v, 32'h96);
    wr(ADDR_STATUS, 32'h10, r);
    wr(ADDR_CTRL, 32'h80, r);
    p.send(8'h11, 40, 1'b1);
    rd(ADDR_STATUS, v, r);
    chk(32'(v[4:2]), 32'h0);
    wr(ADDR_CTRL, 32'h00, r);
    for (int i = 0; i < 8; i++) wr(ADDR_TXDATA, 32'h81 + i, r);
    chk(32'(serial_tx), 32'h1);
    rd(ADDR_STATUS, v, r);
    chk(32'(v[1:0]), 32'h2);
    wr(ADDR_CTRL, 32'hC0, r);
    wr(ADDR_TXDATA, 32'h99, r);
    // eight frames of about 400 cycles each must drain first
    for (int i = 0; i < 200 && !v[0]; i++) begin
      repeat (20) @(posedge aclk);
      rd(ADDR_STATUS, v, r);
    end
    chk(32'(v[6:0]), 32'h21); // empty, last frame still on the line
    // second reset in mid-run
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'(serial_tx), 32'h1);
    rd(ADDR_DIVISOR, v, r);
    chk(v, 32'(DIV_RESET));
    rd(ADDR_CTRL, v, r);
    chk(v, 32'h0);
    complete_run;
  end
  // watchdog: the whole run needs well under this
  initial begin
    repeat (30000) @(posedge aclk);
    n_mismatch++;
    complete_run;
  end
endmodule
`default_nettype wire
